// *** core/dpgc_pkg.sv ***
package dpgc_pkg;

	// register byte addresses on the configuration port
	localparam logic [7:0] LOOP_B_GAIN_ADDR = 8'h6C;
	localparam logic [7:0] LOOP_A_GAIN_ADDR = 8'h6D;
	localparam logic [7:0] PHASE_LOW_ADDR   = 8'h70;

	// values after reset
	localparam logic [7:0] GAIN_CFG_RESET   = 8'hC2;
	localparam logic [7:0] PHASE_LOW_RESET  = 8'h00;

	// field positions inside a detector gain register
	localparam int AUTO_SEL_BIT   = 7;
	localparam int ANALOG_MSB     = 6;
	localparam int ANALOG_LSB     = 4;
	localparam int DIGITAL_MSB    = 2;
	localparam int DIGITAL_LSB    = 0;

	// bit 3 is not implemented and always reads zero
	localparam logic [7:0] GAIN_CFG_MASK = 8'hF7;

	// locking mode reported by a loop datapath
	typedef enum logic [1:0] {
		DPGC_MODE_DIGITAL   = 2'h0,
		DPGC_MODE_ANALOG    = 2'h1,
		DPGC_MODE_ANALOG_8K = 2'h2,
		DPGC_MODE_IDLE      = 2'h3
	} dpgc_mode_t;

endpackage

// *** core/dpgc_gain_sel.sv ***
`timescale 1ns/1ps
// per-loop choice of the second phase detector gain
module dpgc_gain_sel (
	// clock and reset
	input  wire logic                ref_clk,
	input  wire logic                nrst,
	// configuration register and loop state
	input  wire logic [7:0]          gain_cfg,
	input  wire dpgc_pkg::dpgc_mode_t lock_mode,
	input  wire logic [2:0]          gain_8k,
	// selected gain
	output logic                     detector_used,
	output logic [2:0]               detector_gain
);

	typedef struct packed {
		logic       used;
		logic [2:0] gain;
	} dpgc_sel_t;

	dpgc_sel_t state;
	dpgc_sel_t next_state;

	logic       auto_sel;
	logic [2:0] analog_gain;
	logic [2:0] digital_gain;

	assign auto_sel     = gain_cfg[dpgc_pkg::AUTO_SEL_BIT];
	assign analog_gain  = gain_cfg[dpgc_pkg::ANALOG_MSB:dpgc_pkg::ANALOG_LSB];
	assign digital_gain = gain_cfg[dpgc_pkg::DIGITAL_MSB:dpgc_pkg::DIGITAL_LSB];

	////////////////////////////////////////////////////////////////////////////////
	// digital gain is the fallback so the value is never stale when auto is off
	always_comb begin
		next_state      = state;
		next_state.used = auto_sel;
		next_state.gain = digital_gain;
		if (auto_sel) begin
			case (lock_mode)
				dpgc_pkg::DPGC_MODE_DIGITAL: begin
					next_state.gain = digital_gain;
				end
				dpgc_pkg::DPGC_MODE_ANALOG: begin
					next_state.gain = analog_gain;
				end
				dpgc_pkg::DPGC_MODE_ANALOG_8K: begin
					next_state.gain = gain_8k;
				end
				default: begin
					next_state.gain = digital_gain;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign detector_used = state.used;
	assign detector_gain = state.gain;

endmodule

// *** core/dpgc_top.sv ***
// Summary of operation
// - with auto selection on and the loop locked in digital feedback, the gain is the digital field.
// - with the auto selection bit 7 clear, the digital field is the gain in every mode.
// - the analog field bits 6:4 is the gain in analog feedback above 8 kHz and unused when auto is off.
// - each loop gain register is read/write and resets to 8'hC2.
// - the low phase offset byte is read/write and resets to 8'h00.
// - auto bit 0 marks the detector unused, 1 picks the gain by digital, analog or analog 8 kHz mode.
`timescale 1ns/1ps
module dpgc_top (
	// clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 nrst,
	// configuration port, same clock domain
	input  wire logic [7:0]           cfg_addr,
	input  wire logic                 cfg_wr,
	input  wire logic                 cfg_rd,
	input  wire logic [7:0]           cfg_wdata,
	output logic [7:0]                cfg_rdata,
	output logic                      cfg_rvalid,
	// loop a state
	input  wire dpgc_pkg::dpgc_mode_t loop_a_lock_mode,
	input  wire logic [2:0]           loop_a_gain_8k,
	// loop b state
	input  wire dpgc_pkg::dpgc_mode_t loop_b_lock_mode,
	input  wire logic [2:0]           loop_b_gain_8k,
	// second phase detector settings and low phase offset byte
	output logic                      loop_a_second_phase_detector_used,
	output logic [2:0]                loop_a_second_phase_detector_gain,
	output logic                      loop_b_second_phase_detector_used,
	output logic [2:0]                loop_b_second_phase_detector_gain,
	output logic [7:0]                phase_shift_low_byte_out
);

	typedef struct packed {
		logic [7:0] loop_a_detector_gain_cfg;
		logic [7:0] loop_b_detector_gain_cfg;
		logic [7:0] phase_shift_low_byte;
		logic [7:0] rdata;
		logic       rvalid;
	} dpgc_regs_t;

	dpgc_regs_t state;
	dpgc_regs_t next_state;

	////////////////////////////////////////////////////////////////////////////////
	// register writes and registered read data; unmapped reads return zero
	always_comb begin
		next_state        = state;
		next_state.rvalid = cfg_rd;
		next_state.rdata  = 8'h00;
		if (cfg_wr) begin
			case (cfg_addr)
				dpgc_pkg::LOOP_B_GAIN_ADDR: begin
					next_state.loop_b_detector_gain_cfg = cfg_wdata & dpgc_pkg::GAIN_CFG_MASK;
				end
				dpgc_pkg::LOOP_A_GAIN_ADDR: begin
					next_state.loop_a_detector_gain_cfg = cfg_wdata & dpgc_pkg::GAIN_CFG_MASK;
				end
				dpgc_pkg::PHASE_LOW_ADDR: begin
					next_state.phase_shift_low_byte = cfg_wdata;
				end
				default: begin
					next_state.rvalid = cfg_rd;
				end
			endcase
		end
		// read returns the contents before a same-cycle write
		if (cfg_rd) begin
			case (cfg_addr)
				dpgc_pkg::LOOP_B_GAIN_ADDR: begin
					next_state.rdata = state.loop_b_detector_gain_cfg;
				end
				dpgc_pkg::LOOP_A_GAIN_ADDR: begin
					next_state.rdata = state.loop_a_detector_gain_cfg;
				end
				dpgc_pkg::PHASE_LOW_ADDR: begin
					next_state.rdata = state.phase_shift_low_byte;
				end
				default: begin
					next_state.rdata = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state.loop_a_detector_gain_cfg <= dpgc_pkg::GAIN_CFG_RESET;
			state.loop_b_detector_gain_cfg <= dpgc_pkg::GAIN_CFG_RESET;
			state.phase_shift_low_byte     <= dpgc_pkg::PHASE_LOW_RESET;
			state.rdata                    <= 8'h00;
			state.rvalid                   <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	assign cfg_rdata                = state.rdata;
	assign cfg_rvalid               = state.rvalid;
	assign phase_shift_low_byte_out = state.phase_shift_low_byte;

	////////////////////////////////////////////////////////////////////////////////
	// gain choice per loop, registered so every output leaves a flip-flop
	dpgc_gain_sel u_loop_a_sel (
		.ref_clk       (ref_clk),
		.nrst          (nrst),
		.gain_cfg      (state.loop_a_detector_gain_cfg),
		.lock_mode     (loop_a_lock_mode),
		.gain_8k       (loop_a_gain_8k),
		.detector_used (loop_a_second_phase_detector_used),
		.detector_gain (loop_a_second_phase_detector_gain)
	);

	dpgc_gain_sel u_loop_b_sel (
		.ref_clk       (ref_clk),
		.nrst          (nrst),
		.gain_cfg      (state.loop_b_detector_gain_cfg),
		.lock_mode     (loop_b_lock_mode),
		.gain_8k       (loop_b_gain_8k),
		.detector_used (loop_b_second_phase_detector_used),
		.detector_gain (loop_b_second_phase_detector_gain)
	);

endmodule

// *** verif/dpgc_top_properties.sv ***
`timescale 1ns/1ps
module dpgc_checker (
	// clock and reset
	input wire logic                 ref_clk,
	input wire logic                 nrst,
	// configuration port
	input wire logic [7:0]           cfg_addr,
	input wire logic                 cfg_wr,
	input wire logic                 cfg_rd,
	input wire logic [7:0]           cfg_wdata,
	input wire logic [7:0]           cfg_rdata,
	input wire logic                 cfg_rvalid,
	// loop state and detector settings
	input wire dpgc_pkg::dpgc_mode_t loop_a_lock_mode,
	input wire dpgc_pkg::dpgc_mode_t loop_b_lock_mode,
	input wire logic                 loop_a_second_phase_detector_used,
	input wire logic [2:0]           loop_a_second_phase_detector_gain,
	input wire logic [2:0]           loop_b_second_phase_detector_gain
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// write decodes; a second write to the same place next cycle is not expected
	wire       wa = cfg_wr && cfg_addr == 8'h6D;
	wire       wb = cfg_wr && cfg_addr == 8'h6C;
	wire [7:0] d  = cfg_wdata;
	////////////////////////////////////////////////////////////////////////////////
	chk_read_answer: assert property (cfg_rd |=> cfg_rvalid) else $error("no read answer");
	chk_gain_readback: assert property (wa ##1 cfg_rd && cfg_addr == 8'h6D
		|=> cfg_rdata == ($past(d, 2) & 8'hF7)) else $error("gain readback");
	chk_bit3_zero: assert property (cfg_rvalid && $past(cfg_addr[7:1]) == 7'h36
		|-> !cfg_rdata[3]) else $error("bit 3 set");
	chk_phase_readback: assert property (cfg_wr && cfg_addr == 8'h70 ##1 cfg_rd
		&& cfg_addr == 8'h70 |=> cfg_rdata == $past(d, 2)) else $error("phase readback");
	chk_used_follows: assert property (wa |-> ##2
		loop_a_second_phase_detector_used == $past(d[7], 2)) else $error("used flag");
	chk_digital_gain: assert property (wa && d[7] && loop_a_lock_mode == 2'h0 ##1
		loop_a_lock_mode == 2'h0 |=> loop_a_second_phase_detector_gain == $past(d[2:0], 2))
		else $error("digital gain");
	chk_auto_off_gain: assert property (wb && !d[7] |-> ##2
		loop_b_second_phase_detector_gain == $past(d[2:0], 2)) else $error("auto off gain");
	chk_analog_gain: assert property (wb && d[7] && loop_b_lock_mode == 2'h1 ##1
		loop_b_lock_mode == 2'h1 |=> loop_b_second_phase_detector_gain == $past(d[6:4], 2))
		else $error("analog gain");
	// main scenarios
	cover property (wa ##2 !loop_a_second_phase_detector_used);
	cover property (cfg_rvalid && cfg_rdata == 8'hF7);
	cover property (wb && d[7] && loop_b_lock_mode == 2'h1);
endmodule
bind dpgc_top dpgc_checker u_chk (.ref_clk, .nrst, .cfg_addr, .cfg_wr, .cfg_rd, .cfg_wdata,
	.cfg_rdata, .cfg_rvalid, .loop_a_lock_mode, .loop_b_lock_mode,
	.loop_a_second_phase_detector_used, .loop_a_second_phase_detector_gain,
	.loop_b_second_phase_detector_gain);

// *** verif/test_dpgc_top.sv ***
`timescale 1ns/1ps
module test_dpgc_top;
	logic                 ref_clk = 0, nrst = 0, cfg_wr = 0, cfg_rd = 0, cfg_rvalid, ua, ub;
	logic [7:0]           cfg_addr = 8'h00, cfg_wdata = 8'h00, cfg_rdata, phase;
	logic [2:0]           ga, gb, g8a = 3'h1, g8b = 3'h6;
	dpgc_pkg::dpgc_mode_t ma = dpgc_pkg::DPGC_MODE_DIGITAL, mb = dpgc_pkg::DPGC_MODE_DIGITAL;
	int                   err_total = 0, checks = 0, cyc_n = 0;
	always #25 ref_clk = ~ref_clk;
	dpgc_top uut (.ref_clk, .nrst, .cfg_addr, .cfg_wr, .cfg_rd, .cfg_wdata, .cfg_rdata, .cfg_rvalid,
		.loop_a_lock_mode(ma), .loop_a_gain_8k(g8a), .loop_b_lock_mode(mb), .loop_b_gain_8k(g8b),
		.loop_a_second_phase_detector_used(ua), .loop_a_second_phase_detector_gain(ga),
		.loop_b_second_phase_detector_used(ub), .loop_b_second_phase_detector_gain(gb),
		.phase_shift_low_byte_out(phase));
	// hang guard, far above the thirty or so cycles the run needs
	always @(posedge ref_clk) begin
		cyc_n++;
		if (cyc_n == 3000) begin
			err_total++;
			test_done();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task cmp(input logic [8:0] g, input logic [8:0] e);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	// no idle cycle after a write, so a read can follow back to back
	task wr(input logic [7:0] a, input logic [7:0] v);
		cfg_wr = 1;
		cfg_addr = a;
		cfg_wdata = v;
		cyc(1);
		cfg_wr = 0;
	endtask
	// answer stands one cycle only, so it is sampled at the first falling edge
	task rd(input logic [7:0] a, input logic [7:0] e);
		cfg_rd = 1;
		cfg_addr = a;
		cyc(1);
		cfg_rd = 0;
		cmp({cfg_rvalid, cfg_rdata}, {1'b1, e});
		cyc(1);
	endtask
	task t_reset;
		rd(8'h6C, 8'hC2);
		rd(8'h6D, 8'hC2);
		rd(8'h70, 8'h00);
		cmp({5'h00, ua, ga}, {5'h00, 1'b1, 3'h2});
	endtask
	task t_rw;
		wr(8'h6D, 8'hFF);
		rd(8'h6D, 8'hF7);
		wr(8'h70, 8'hA5);
		rd(8'h70, 8'hA5);
		cmp({1'b0, phase}, 9'h0A5);
		rd(8'h55, 8'h00);
	endtask
	task t_modes;
		mb = dpgc_pkg::DPGC_MODE_ANALOG;
		wr(8'h6C, 8'hB5);
		cyc(1);
		cmp({5'h00, ub, gb}, {5'h00, 1'b1, 3'h3});
		mb = dpgc_pkg::DPGC_MODE_DIGITAL;
		cyc(1);
		cmp({6'h00, gb}, 9'h005);
		mb = dpgc_pkg::DPGC_MODE_ANALOG_8K;
		cyc(1);
		cmp({6'h00, gb}, 9'h006);
		wr(8'h6C, 8'h35);
		cyc(1);
		cmp({5'h00, ub, gb}, {5'h00, 1'b0, 3'h5});
		mb = dpgc_pkg::DPGC_MODE_ANALOG;
		cyc(1);
		cmp({6'h00, gb}, 9'h005);
		wr(8'h6D, 8'h92);
		cyc(1);
		cmp({5'h00, ua, ga}, {5'h00, 1'b1, 3'h2});
		// idle falls back to the digital field, 8 kHz takes the loop's own input
		ma = dpgc_pkg::DPGC_MODE_IDLE;
		cyc(1);
		cmp({6'h00, ga}, 9'h002);
		ma = dpgc_pkg::DPGC_MODE_ANALOG_8K;
		cyc(1);
		cmp({6'h00, ga}, 9'h001);
	endtask
	task test_done;
		$display("checks=%0d err_total=%0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// reset for three cycles, released off the sampling edge
	initial begin
		cyc(3);
		nrst = 1;
		t_reset();
		t_rw();
		t_modes();
		test_done();
	end
endmodule
